// *** logic/frsf_pkg.sv ***
// shared constants and carrier types for the flash ready/status flags block
package frsf_pkg;
    // status word layout
    localparam int STAT_W = 16;
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_FAIL = 5;
    localparam int BIT_EWIN = 3;
    localparam int BIT_STOG = 2;
    localparam logic [15:0] STAT_RESERVED_VAL = 16'h0000;
    // timing, in their own units
    localparam int CLK_MHZ = 100;
    localparam int PROT_FLAG_US = 100;
    localparam int ERASE_WIN_US = 96;
    localparam int PROT_FLAG_CYC = PROT_FLAG_US * CLK_MHZ;
    localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
    // engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_EWIN = 3'h1,
        ST_ERASE = 3'h2,
        ST_SUSP = 3'h3,
        ST_PROG = 3'h4,
        ST_SPROG = 3'h5,
        ST_PROT = 3'h6
    } frsf_state_t;
    // operation start requests from the command decoder
    typedef struct packed {
        logic prog;
        logic erase_sel;
        logic suspend;
        logic resume;
        logic prot_hit;
        logic [15:0] wdata;
    } frsf_cmd_t;
    // array-side progress events
    typedef struct packed {
        logic prog_done;
        logic erase_done;
        logic fail;
    } frsf_evt_t;
endpackage

// *** logic/frsf_timer.sv ***
// down-counter that flags expiry of a loaded cycle count
`timescale 1ns/1ns
`default_nettype none
module frsf_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // control
    input wire logic i_load,
    input wire logic [W-1:0] i_count,
    input wire logic i_clear,
    // status
    output logic o_running,
    output logic o_expired
);
    logic [W-1:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic exp_q, exp_d;

    // next count: load wins over clear so a fresh window restarts cleanly
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (i_load) begin
            cnt_d = i_count;
            run_d = 1'b1;
        end else if (i_clear) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q <= W'(1)) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - W'(1);
            end
        end
    end

    // registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign o_running = run_q;
    assign o_expired = exp_q;
endmodule
`default_nettype wire

// *** logic/frsf_status.sv ***
// busy line and status word generation for the flash erase/program engine
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - busy high during operation, refuse new ones
// R2 - busy low when ready or suspended
// R3 - busy feeds irq node, falling edge interrupts
// R4 - array reads return status while active
// R5 - flags at bits 7,6,5,3,2; rest reserved
// R6 - software masks reserved status bits
// R7 - software polls via poll/toggle/fail/window flags
// R8 - erase: poll flag 0 busy, 1 done
// R9 - protected erase: poll 0 for 100us
// R10 - suspend entry switches poll flag to 1
// R11 - program in suspend polls like normal
// R12 - program: poll flag complements written bit7
// R13 - toggle flag inverts on every status read
// R14 - status read at program or erase address
// R15 - erase starts after window; extra selects accepted
module frsf_status #(
    parameter int PROT_CYC = frsf_pkg::PROT_FLAG_CYC,
    parameter int EWIN_CYC = frsf_pkg::ERASE_WIN_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // commands and array events
    input wire frsf_pkg::frsf_cmd_t i_cmd,
    input wire frsf_pkg::frsf_evt_t i_evt,
    // processor read port
    input wire logic i_rd,
    input wire logic i_rd_in_target,
    input wire logic [15:0] i_array_data,
    output logic [15:0] o_rdata,
    // busy line to the extra peripheral irq node
    output logic o_busy,
    output logic o_busy_fall,
    // erase start strobe to the array and command-refused pulse
    output logic o_erase_start,
    output logic o_cmd_refused
);
    localparam int TW = 16;
    frsf_pkg::frsf_state_t st_q, st_d;
    logic [15:0] rdata_q, rdata_d;
    logic busy_q, busy_d;
    logic fall_q, fall_d;
    logic estart_q, estart_d;
    logic refuse_q, refuse_d;
    logic tog_q, tog_d;
    logic stog_q, stog_d;
    logic fail_q, fail_d;
    logic poll_q, poll_d;
    logic wbit7_q, wbit7_d;
    logic t_load, t_clear, t_run, t_exp;
    logic [TW-1:0] t_count;

    // one timer serves both the erase window and the protected-block flag
    frsf_timer #(.W(TW)) u_timer (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_load(t_load),
        .i_count(t_count),
        .i_clear(t_clear),
        .o_running(t_run),
        .o_expired(t_exp)
    );

    // active means the engine owns the array; suspend releases it
    function automatic logic is_active(input frsf_pkg::frsf_state_t s);
        return s != frsf_pkg::ST_IDLE && s != frsf_pkg::ST_SUSP;
    endfunction

    // assemble status word; reserved bits read as zero
    function automatic logic [15:0] stat_word(input logic p, input logic t, input logic f,
                                              input logic e, input logic s);
        logic [15:0] w;
        w = frsf_pkg::STAT_RESERVED_VAL;
        w[frsf_pkg::BIT_POLL] = p;
        w[frsf_pkg::BIT_TOGGLE] = t;
        w[frsf_pkg::BIT_FAIL] = f;
        w[frsf_pkg::BIT_EWIN] = e;
        w[frsf_pkg::BIT_STOG] = s;
        return w;
    endfunction

    // engine sequencing and flag updates
    always_comb begin
        st_d = st_q;
        poll_d = poll_q;
        wbit7_d = wbit7_q;
        fail_d = fail_q | i_evt.fail;
        estart_d = 1'b0;
        refuse_d = 1'b0;
        t_load = 1'b0;
        t_clear = 1'b0;
        t_count = TW'(EWIN_CYC);
        unique case (st_q)
            frsf_pkg::ST_IDLE, frsf_pkg::ST_SUSP: begin
                if (i_cmd.prog) begin
                    st_d = (st_q == frsf_pkg::ST_SUSP) ? frsf_pkg::ST_SPROG : frsf_pkg::ST_PROG; // [R11]
                    wbit7_d = i_cmd.wdata[frsf_pkg::BIT_POLL];
                    poll_d = ~i_cmd.wdata[frsf_pkg::BIT_POLL]; // [R12]
                    fail_d = i_evt.fail; // a failure landing with the start still wins over the clear
                end else if (st_q == frsf_pkg::ST_SUSP && i_cmd.resume) begin
                    st_d = frsf_pkg::ST_ERASE;
                    poll_d = 1'b0;
                end else if (st_q == frsf_pkg::ST_IDLE && i_cmd.erase_sel && i_cmd.prot_hit) begin
                    st_d = frsf_pkg::ST_PROT;
                    poll_d = 1'b0; // [R9]
                    t_load = 1'b1;
                    t_count = TW'(PROT_CYC);
                end else if (st_q == frsf_pkg::ST_IDLE && i_cmd.erase_sel) begin
                    st_d = frsf_pkg::ST_EWIN;
                    poll_d = 1'b0;
                    fail_d = i_evt.fail; // set wins over the start-of-operation clear
                    t_load = 1'b1; // [R15]
                end
            end
            frsf_pkg::ST_EWIN: begin
                if (i_cmd.erase_sel && !i_cmd.prot_hit) begin
                    t_load = 1'b1; // extra block restarts the window [R15]
                end else if (t_exp) begin
                    st_d = frsf_pkg::ST_ERASE;
                    estart_d = 1'b1; // [R15]
                end
                refuse_d = i_cmd.prog;
            end
            frsf_pkg::ST_ERASE: begin
                refuse_d = i_cmd.prog | i_cmd.erase_sel; // [R1]
                if (i_evt.erase_done) begin
                    st_d = frsf_pkg::ST_IDLE;
                    poll_d = 1'b1; // [R8]
                end else if (i_cmd.suspend) begin
                    st_d = frsf_pkg::ST_SUSP;
                    poll_d = 1'b1; // [R10]
                end
            end
            frsf_pkg::ST_PROG, frsf_pkg::ST_SPROG: begin
                refuse_d = i_cmd.prog | i_cmd.erase_sel; // [R1]
                if (i_evt.prog_done) begin
                    st_d = (st_q == frsf_pkg::ST_SPROG) ? frsf_pkg::ST_SUSP : frsf_pkg::ST_IDLE;
                    poll_d = wbit7_q; // [R12]
                end
            end
            frsf_pkg::ST_PROT: begin
                refuse_d = i_cmd.prog | i_cmd.erase_sel;
                if (t_exp) begin
                    st_d = frsf_pkg::ST_IDLE; // back to array data [R9]
                    t_clear = 1'b1;
                end
            end
            default: st_d = frsf_pkg::ST_IDLE;
        endcase
    end

    // busy line and read path; busy low when suspended
    always_comb begin
        logic rd_stat;
        rd_stat = i_rd && is_active(st_q) && i_rd_in_target; // [R4] [R14]
        busy_d = is_active(st_d) && st_d != frsf_pkg::ST_PROT; // [R1] [R2]
        if (st_d == frsf_pkg::ST_PROT) begin
            busy_d = 1'b1;
        end
        fall_d = busy_q && !busy_d; // [R3]
        tog_d = tog_q ^ rd_stat; // [R13]
        stog_d = stog_q ^ (rd_stat && st_q != frsf_pkg::ST_PROG); // erase-mode toggle
        if (i_rd) begin
            rdata_d = rd_stat ? stat_word(poll_q, tog_q, fail_q, st_q == frsf_pkg::ST_EWIN, stog_q)
                              : i_array_data; // [R5]
        end else begin
            rdata_d = rdata_q;
        end
    end

    // registers; every output comes from here
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= frsf_pkg::ST_IDLE;
            rdata_q <= 16'h0000;
            busy_q <= 1'b0;
            fall_q <= 1'b0;
            estart_q <= 1'b0;
            refuse_q <= 1'b0;
            tog_q <= 1'b0;
            stog_q <= 1'b0;
            fail_q <= 1'b0;
            poll_q <= 1'b0;
            wbit7_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rdata_q <= rdata_d;
            busy_q <= busy_d;
            fall_q <= fall_d;
            estart_q <= estart_d;
            refuse_q <= refuse_d;
            tog_q <= tog_d;
            stog_q <= stog_d;
            fail_q <= fail_d;
            poll_q <= poll_d;
            wbit7_q <= wbit7_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_busy = busy_q;
    assign o_busy_fall = fall_q;
    assign o_erase_start = estart_q;
    assign o_cmd_refused = refuse_q;

    // busy tracks the running operation, low in suspend
    a_busy_matches_state: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        busy_q == (st_q != frsf_pkg::ST_IDLE && st_q != frsf_pkg::ST_SUSP)) // [R1]
        else $error("busy line disagrees with engine state");
    a_suspend_not_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        st_q == frsf_pkg::ST_SUSP |-> !busy_q) // [R2]
        else $error("busy high while suspended");
    a_fall_pulse_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fall_q |-> !busy_q && $past(busy_q)) // [R3]
        else $error("ready event without busy drop");
    a_prog_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        busy_q && i_cmd.prog |=> refuse_q) // [R1]
        else $error("program accepted while busy");
    a_status_on_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_rd && i_rd_in_target && busy_q |=> o_rdata[15:8] == 8'h00 && !o_rdata[4] && o_rdata[1:0] == 2'h0) // [R5]
        else $error("reserved status bits not zero");
    a_erase_done_poll: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        st_q == frsf_pkg::ST_ERASE && i_evt.erase_done |=> poll_q && !busy_q) // [R8]
        else $error("poll flag not set after erase");
    a_suspend_poll_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        st_q == frsf_pkg::ST_ERASE && i_cmd.suspend && !i_evt.erase_done |=> poll_q && st_q == frsf_pkg::ST_SUSP) // [R10]
        else $error("suspend entry did not set poll flag");
    a_prog_poll_inv: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st_q == frsf_pkg::ST_IDLE || st_q == frsf_pkg::ST_SUSP) && i_cmd.prog
        |=> poll_q == !$past(i_cmd.wdata[frsf_pkg::BIT_POLL])) // [R12] [R11]
        else $error("poll flag not complement of written bit");
    a_toggle_on_read: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_rd && i_rd_in_target && busy_q |=> tog_q != $past(tog_q)) // [R13]
        else $error("toggle flag did not invert");
    a_erase_waits_window: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(st_q == frsf_pkg::ST_EWIN) |-> !estart_q [*2]) // [R15]
        else $error("erase started before window");
endmodule
`default_nettype wire

// *** testbench/frsf_cpu_model.sv ***
// processor-side read model for the flash status block
`timescale 1ns/1ns
`default_nettype none
module frsf_cpu_model (
    // clock
    input wire logic i_mclk,
    // returned word
    input wire logic [15:0] i_rdata,
    // read request and array content
    output logic o_rd,
    output logic o_in_target,
    output logic [15:0] o_array_data
);
    // ==========
    // array word seen when no operation runs
    logic [15:0] word = 16'hffff;
    assign o_array_data = word;
    initial begin
        o_rd = 1'b0;
        o_in_target = 1'b0;
    end
    // one read launched and dropped at falling edges; the answer is settled a cycle later
    task automatic read(input logic tgt, output logic [15:0] d, output logic [15:0] m);
        @(negedge i_mclk);
        o_rd = 1'b1;
        o_in_target = tgt;
        @(negedge i_mclk);
        o_rd = 1'b0;
        @(negedge i_mclk);
        d = i_rdata;
        m = i_rdata & 16'h00ec; // only the defined flags are kept
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the flash ready/status flags block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    // ==========
    // short counts keep the run brief
    localparam int PROT = 20;
    localparam int EWIN = 10;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    frsf_pkg::frsf_cmd_t cmd = '0;
    frsf_pkg::frsf_evt_t evt = '0;
    logic rd, tgt, busy, bfall, estart, refused;
    logic [15:0] adata, rdata, d, d2, m;
    int fail_count = 0;
    int check_count = 0;
    int falls = 0;
    int starts = 0;
    int refusals = 0;
    always #5 i_mclk = ~i_mclk;
    frsf_status #(.PROT_CYC(PROT), .EWIN_CYC(EWIN)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd(cmd),
        .i_evt(evt), .i_rd(rd), .i_rd_in_target(tgt), .i_array_data(adata), .o_rdata(rdata), .o_busy(busy),
        .o_busy_fall(bfall), .o_erase_start(estart), .o_cmd_refused(refused));
    frsf_cpu_model cpu (.i_mclk(i_mclk), .i_rdata(rdata), .o_rd(rd), .o_in_target(tgt), .o_array_data(adata));
    // one-cycle pulses are counted at every rising edge so no check can miss them
    always @(posedge i_mclk) begin
        if (bfall === 1'b1) falls++;
        if (estart === 1'b1) starts++;
        if (refused === 1'b1) refusals++;
    end
    // ==========
    task automatic summarize();
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // f is prog, erase_sel, suspend, resume, prot_hit; prot_hit stays as a level
    task automatic cmdp(input logic [4:0] f, input logic [15:0] w);
        @(negedge i_mclk);
        cmd = {f, w};
        @(negedge i_mclk);
        cmd = {4'h0, f[0], w};
    endtask
    task automatic ev(input logic [2:0] e);
        @(negedge i_mclk);
        evt = e;
        @(negedge i_mclk);
        evt = '0;
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 200 && busy !== lvl; i++) @(negedge i_mclk);
        if (busy !== lvl) begin
            fail_count++;
            summarize();
        end
    endtask
    // ==========
    task automatic t_program();
        cpu.word = 16'h0080;
        cmdp(5'h10, 16'h0080);
        step(1);
        `CHK("busy", 1'b1, busy)
        cpu.read(1'b1, d, m);
        `CHK("poll", 1'b0, d[7])
        `CHK("reserved", 16'h0000, d & 16'hff13)
        cpu.read(1'b1, d2, m);
        `CHK("toggle", ~d[6], d2[6])
        cpu.read(1'b0, d2, m);
        `CHK("off target", 16'h0080, d2)
        cmdp(5'h10, 16'h0000);
        step(2);
        `CHK("refused", 1, refusals)
        ev(3'h1);
        cpu.read(1'b1, d, m);
        `CHK("fail", 1'b1, d[5])
        `CHK("masked", d, m)
        ev(3'h4);
        wait_busy(1'b0);
        step(1);
        `CHK("falls", 1, falls)
        cpu.read(1'b1, d, m);
        `CHK("done word", 16'h0080, d)
    endtask
    task automatic t_erase();
        int n;
        cpu.word = 16'hffff;
        cmdp(5'h08, 16'h0000);
        cpu.read(1'b1, d, m);
        `CHK("window", 1'b1, d[3])
        `CHK("busy win", 1'b1, busy)
        cmdp(5'h08, 16'h0000);
        for (n = 0; n < 100 && starts == 0; n++) @(negedge i_mclk);
        `CHK("restart", 1'b1, n >= EWIN - 2 && n <= EWIN + 3)
        cpu.read(1'b1, d, m);
        `CHK("erase poll", 1'b0, d[7])
        cmdp(5'h04, 16'h0000);
        step(2);
        `CHK("busy susp", 1'b0, busy)
        cpu.read(1'b1, d, m);
        `CHK("susp poll", 1'b1, d[7])
        // array bit 7 low so the status word must be what shows bit 7 high
        cpu.word = 16'h0000;
        cmdp(5'h10, 16'h0000);
        cpu.read(1'b1, d, m);
        `CHK("susp prog", 1'b1, d[7])
        cpu.word = 16'hffff;
        ev(3'h4);
        wait_busy(1'b0);
        cmdp(5'h02, 16'h0000);
        wait_busy(1'b1);
        ev(3'h2);
        wait_busy(1'b0);
        cpu.read(1'b1, d, m);
        `CHK("erased", 16'hffff, d)
    endtask
    task automatic t_protect();
        int n;
        cpu.word = 16'h12b4;
        cmdp(5'h09, 16'h0000);
        cpu.read(1'b1, d, m);
        `CHK("prot poll", 1'b0, d[7])
        for (n = 0; n < 200 && busy === 1'b1; n++) @(negedge i_mclk);
        `CHK("prot time", 1'b1, n >= PROT - 8 && n <= PROT)
        cpu.read(1'b1, d, m);
        `CHK("prot data", 16'h12b4, d)
    endtask
    // ==========
    initial begin
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        step(1);
        `CHK("busy idle", 1'b0, busy)
        t_program();
        t_erase();
        t_protect();
        summarize();
    end
endmodule
`default_nettype wire
